// *** verilog/dmmrp_pkg.sv ***
/*
 * shared constants, state codes and bundles for the memory-to-memory
 * read phase of the dma sequencer.
 * assumes one clock domain and a synchronous active-low reset.
 */
package dmmrp_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int MODE_W = 8;

    // position of the memory-to-memory bit in a channel mode register
    localparam int MODE_M2M_BIT = 0;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    // cycles spent in every read state other than the wait state
    localparam int STEP_CYCLES = 1;

    typedef enum logic [5:0] {
        ST_IDLE      = 6'h01,
        M2M_READ_S1  = 6'h02,
        M2M_READ_S2  = 6'h04,
        M2M_READ_S3  = 6'h08,
        M2M_READ_S4  = 6'h10,
        M2M_WRITE_S1 = 6'h20
    } dmmrp_state_e;

    // address sources offered by the channel register file
    typedef struct packed {
        logic [ADDR_W-1:0] ch0Cur;
        logic [ADDR_W-1:0] ch1Cur;
        logic [ADDR_W-1:0] srcAddr;
        logic [ADDR_W-1:0] dstAddr;
    } dmmrp_addr_s;

    // request information from the arbiter side
    typedef struct packed {
        logic legacyMode;
        logic m2mCmdEn;
        logic dreq0;
        logic ch0Top;
        logic [MODE_W-1:0] modeReg;
    } dmmrp_req_s;

    // system bus outputs
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic addrDrive;
        logic aen;
        logic memRdN;
        logic memWrN;
        logic dackN;
    } dmmrp_bus_s;

endpackage : dmmrp_pkg

// *** verilog/dmmrp_temp_reg.sv ***
/*
 * temporary holding register for one word read from memory.
 * assumes load is a one-cycle pulse; output comes from a flip-flop.
 */
`timescale 1ns/1ps
module dmmrp_temp_reg (
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [dmmrp_pkg::DATA_W-1:0] dataIn,
    output logic [dmmrp_pkg::DATA_W-1:0] dataOut
);
    import dmmrp_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] word;
    } dmmrp_temp_s;

    dmmrp_temp_s r_q;
    dmmrp_temp_s r_d;

    always_comb begin
        r_d = r_q;
        if (load) begin
            r_d.word = dataIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_q.word <= DATA_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign dataOut = r_q.word;

endmodule : dmmrp_temp_reg

// *** verilog/dmmrp_read_phase.sv ***
/*
 * read phase of the memory-to-memory transfer: source address out,
 * read strobe, wait on ready, capture into the temporary register,
 * then the first write state which presents the destination address.
 * assumes the bus grant and ready inputs are synchronous to clk and
 * that the channel address and mode registers live outside.
 */
// How it works
// - granted m2m request enters read state one
// - extended mode: mode bit zero selects m2m
// - no peripheral acknowledge during m2m
// - state one: aen on, strobes off
// - legacy mode: channel 0 current address
// - extended mode: source address register
// - state one always moves to state two
// - end-of-process stops service after cycle
// - state two asserts read strobe
// - state three waits while ready high
// - ready low moves to state four
// - state four drops strobe, loads temp
// - state four goes to write state one
// - write one: channel 1 or destination
`timescale 1ns/1ps
module dmmrp_read_phase (
    input wire logic clk,
    input wire logic nrst,
    input wire logic busGrant,
    input wire dmmrp_pkg::dmmrp_req_s req,
    input wire dmmrp_pkg::dmmrp_addr_s addrIn,
    input wire logic readyWait,
    input wire logic eopIn_n,
    input wire logic [dmmrp_pkg::DATA_W-1:0] dataIn,
    output dmmrp_pkg::dmmrp_bus_s bus,
    output logic [dmmrp_pkg::DATA_W-1:0] tempData,
    output logic tempLoad,
    output logic writeStart,
    output logic eopPending,
    output logic ioPath,
    output logic [5:0] stateCode
);
    import dmmrp_pkg::*;

    typedef struct packed {
        dmmrp_state_e st;
        dmmrp_bus_s bus;
        logic load;
        logic wrStart;
        logic eopSeen;
        logic io;
    } dmmrp_core_s;

    dmmrp_core_s r_q;
    dmmrp_core_s r_d;

    // pick channel address in legacy mode, else the extended register
    function automatic logic [ADDR_W-1:0] pickAddr(
        input logic legacy,
        input logic [ADDR_W-1:0] chanAddr,
        input logic [ADDR_W-1:0] extAddr
    );
        logic [ADDR_W-1:0] sel;
        sel = legacy ? chanAddr : extAddr;
        return sel;
    endfunction : pickAddr

    // decide whether the granted request is memory-to-memory
    function automatic logic m2mDetect(
        input dmmrp_req_s r
    );
        logic hit;
        // mode bit zero in extended mode
        if (r.legacyMode) begin
            // legacy: command enable, channel 0 request and priority
            hit = r.m2mCmdEn && r.dreq0 && r.ch0Top;
        end else begin
            hit = r.modeReg[MODE_M2M_BIT];
        end
        return hit;
    endfunction : m2mDetect

    logic isM2m;
    logic inM2m;

    assign isM2m = m2mDetect(req);

    assign inM2m = (r_q.st != ST_IDLE);

    always_comb begin
        r_d = r_q;
        r_d.load = 1'b0;
        r_d.wrStart = 1'b0;
        r_d.io = 1'b0;
        r_d.bus.dackN = 1'b1;
        r_d.bus.memWrN = 1'b1;

        // catch end of process
        // set only; the clear in idle never meets a set
        if (inM2m && !eopIn_n) begin
            r_d.eopSeen = 1'b1;
        end

        unique case (r_q.st)
            ST_IDLE: begin
                // busGrant is looked at only here; later states ignore it
                r_d.bus.aen = 1'b0;
                r_d.bus.addrDrive = 1'b0;
                r_d.bus.memRdN = 1'b1;
                r_d.eopSeen = 1'b0;
                if (busGrant) begin
                    if (isM2m) begin
                        r_d.st = M2M_READ_S1;
                        r_d.bus.aen = 1'b1;
                        r_d.bus.addrDrive = 1'b1;
                        r_d.bus.memRdN = 1'b1;
                        r_d.bus.addr = pickAddr(req.legacyMode,
                            addrIn.ch0Cur, addrIn.srcAddr);
                    end else begin
                        r_d.io = 1'b1;
                    end
                end
            end
            M2M_READ_S1: begin
                r_d.st = M2M_READ_S2;
                r_d.bus.memRdN = 1'b0;
            end
            M2M_READ_S2: begin
                r_d.st = M2M_READ_S3;
                r_d.bus.memRdN = 1'b0;
            end
            M2M_READ_S3: begin
                if (!readyWait) begin
                    r_d.st = M2M_READ_S4;
                    // strobe off, load temp
                    // the load is registered, so the word is taken on
                    // the edge that ends state four
                    r_d.bus.memRdN = 1'b1;
                    r_d.load = 1'b1;
                end else begin
                    r_d.st = M2M_READ_S3;
                    r_d.bus.memRdN = 1'b0;
                end
            end
            M2M_READ_S4: begin
                r_d.st = M2M_WRITE_S1;
                r_d.bus.addr = pickAddr(req.legacyMode,
                    addrIn.ch1Cur, addrIn.dstAddr);
                // temp register keeps the word from here on
                r_d.wrStart = 1'b1;
            end
            M2M_WRITE_S1: begin
                // write phase continues elsewhere; release here
                // eop flag is left set for the write phase to act on
                r_d.st = ST_IDLE;
                r_d.bus.aen = 1'b0;
                r_d.bus.addrDrive = 1'b0;
            end
            default: begin
                // illegal one-hot code: back to idle, bus released
                r_d.st = ST_IDLE;
                r_d.bus.aen = 1'b0;
                r_d.bus.addrDrive = 1'b0;
                r_d.bus.memRdN = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            // constants only: every output goes inactive
            r_q.st <= ST_IDLE;
            r_q.bus.addr <= ADDR_RST;
            r_q.bus.addrDrive <= 1'b0;
            r_q.bus.aen <= 1'b0;
            r_q.bus.memRdN <= 1'b1;
            r_q.bus.memWrN <= 1'b1;
            r_q.bus.dackN <= 1'b1;
            r_q.load <= 1'b0;
            r_q.wrStart <= 1'b0;
            r_q.eopSeen <= 1'b0;
            r_q.io <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    dmmrp_temp_reg u_temp (
        .clk(clk),
        .nrst(nrst),
        .load(r_q.load),
        .dataIn(dataIn),
        .dataOut(tempData)
    );

    assign bus = r_q.bus;
    assign tempLoad = r_q.load;
    assign writeStart = r_q.wrStart;
    // stop request for the write phase
    // the read cycle always completes; the write phase stops on this
    assign eopPending = r_q.eopSeen;
    assign ioPath = r_q.io;
    assign stateCode = r_q.st;

endmodule : dmmrp_read_phase

// *** test/dmmrp_checker.sv ***
/* port assertions for the m2m read phase.
   assumes one clock and sync active-low nrst. */
`timescale 1ns/1ps
module dmmrp_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic busGrant,
    input wire dmmrp_pkg::dmmrp_req_s req,
    input wire logic readyWait,
    input wire logic eopIn_n,
    input wire dmmrp_pkg::dmmrp_bus_s bus,
    input wire logic tempLoad,
    input wire logic writeStart,
    input wire logic eopPending,
    input wire logic ioPath,
    input wire logic [5:0] stateCode
);
    import dmmrp_pkg::*;
    logic m2m;
    assign m2m = req.legacyMode ? (req.m2mCmdEn & req.dreq0 & req.ch0Top)
        : req.modeReg[MODE_M2M_BIT];
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence rdSteps;
        stateCode == 6'h04 && !bus.memRdN ##1 stateCode == 6'h08;
    endsequence
    sequence rdDone;
        stateCode == 6'h10 && tempLoad && bus.memRdN
            ##1 stateCode == 6'h20 && writeStart;
    endsequence
    grant_entry_a:
    assert property (stateCode == 6'h01 && busGrant && m2m |=> stateCode
        == 6'h02 && bus.aen && bus.memRdN && bus.memWrN)
        else $error("m2m grant not entering read state one");
    io_path_a:
    assert property (stateCode == 6'h01 && busGrant && !m2m
        |=> ioPath && stateCode == 6'h01) else $error("io path missed");
    no_ack_a:
    assert property (stateCode != 6'h01 |-> bus.dackN && bus.memWrN)
        else $error("acknowledge or write strobe active");
    read_steps_a:
    assert property (stateCode == 6'h02 |=> rdSteps)
        else $error("read states one and two out of order");
    wait_hold_a:
    assert property (stateCode == 6'h08 && readyWait
        |=> stateCode == 6'h08 && !bus.memRdN) else $error("wait lost");
    wait_exit_a:
    assert property (stateCode == 6'h08 && !readyWait |=> rdDone)
        else $error("read end sequence wrong");
    eop_flag_a:
    assert property (stateCode == 6'h02 && !eopIn_n
        |=> eopPending && stateCode == 6'h04) else $error("eop handling");
    aen_hold_a:
    assert property (stateCode == 6'h04 |-> bus.aen && $stable(bus.addr))
        else $error("address not held in read state two");
    addr_drive_a:
    assert property (bus.addrDrive == (stateCode != 6'h01)
        && bus.aen == bus.addrDrive) else $error("address drive wrong");
endmodule : dmmrp_checker
bind dmmrp_read_phase dmmrp_checker i_chk (.clk(clk), .nrst(nrst),
    .busGrant(busGrant), .req(req), .readyWait(readyWait),
    .eopIn_n(eopIn_n), .bus(bus), .tempLoad(tempLoad),
    .writeStart(writeStart), .eopPending(eopPending), .ioPath(ioPath),
    .stateCode(stateCode));

// *** test/dmmrp_mem_model.sv ***
/* memory answering the read strobe with a set wait.
   assumes a registered active-low strobe. */
`timescale 1ns/1ps
module dmmrp_mem_model (
    input wire logic clk,
    input wire logic memRdN,
    input wire logic [7:0] waitCycles,
    input wire logic [dmmrp_pkg::DATA_W-1:0] word,
    output logic readyWait,
    output logic [dmmrp_pkg::DATA_W-1:0] dataIn
);
    logic [7:0] cnt;
    logic holdQ;
    always_ff @(posedge clk) begin
        cnt <= memRdN ? 8'h00 : cnt + 8'h01;
        holdQ <= !memRdN && !readyWait;
    end
    assign readyWait = !memRdN && cnt <= waitCycles;
    // word held one cycle past the strobe, inverted otherwise
    assign dataIn = (!memRdN && !readyWait) || holdQ ? word : ~word;
endmodule : dmmrp_mem_model

// *** test/dmmrp_read_phase_tb.sv ***
/* self-checking bench for the m2m read phase.
   assumes the checker binds; the memory model is instantiated here. */
`timescale 1ns/1ps
module dmmrp_read_phase_tb;
    import dmmrp_pkg::*;
    typedef struct packed {
        logic io;
        logic eop;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
        logic [DATA_W-1:0] data;
    } dmmrp_note_s;
    logic clk = 0;
    logic nrst = 0;
    logic busGrant = 0;
    logic eopIn_n = 1;
    dmmrp_req_s req = '0;
    dmmrp_addr_s addrIn = '0;
    logic [7:0] waitCycles = 8'h00;
    logic [DATA_W-1:0] word = '0;
    logic [DATA_W-1:0] dataIn, tempData;
    logic readyWait, tempLoad, writeStart, eopPending, ioPath;
    logic [5:0] stateCode;
    dmmrp_bus_s bus;
    dmmrp_note_s notes[$];
    dmmrp_note_s n;
    int errors = 0, samples_checked = 0, seed = 32'h6acc, i;
    always #2 clk = ~clk;
    dmmrp_read_phase i_dut (.clk(clk), .nrst(nrst), .busGrant(busGrant),
        .req(req), .addrIn(addrIn), .readyWait(readyWait),
        .eopIn_n(eopIn_n), .dataIn(dataIn), .bus(bus), .tempData(tempData),
        .tempLoad(tempLoad), .writeStart(writeStart),
        .eopPending(eopPending), .ioPath(ioPath), .stateCode(stateCode));
    dmmrp_mem_model i_mem (.clk(clk), .memRdN(bus.memRdN),
        .waitCycles(waitCycles), .word(word), .readyWait(readyWait),
        .dataIn(dataIn));
    task check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task complete_run;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // grant taken at idle, inputs held until back in idle
    task run_one;
        logic [31:0] r;
        dmmrp_note_s w;
        int k;
        r = $random(seed);
        req = r[11:0];
        if (i % 4 == 0) begin
            // legacy m2m: mode, enable, request, priority all set
            req[11:8] = 4'hF;
        end else if (i % 4 == 1) begin
            req.legacyMode = 1'b0;
            req.modeReg[MODE_M2M_BIT] = 1'b1;
        end
        addrIn = {$random(seed), $random(seed), $random(seed), $random(seed)};
        word = $random(seed);
        waitCycles = {6'h00, r[13:12]};
        eopIn_n = r[14];
        w.eop = !r[14];
        w.io = !(req.legacyMode ? req.m2mCmdEn & req.dreq0 & req.ch0Top
            : req.modeReg[MODE_M2M_BIT]);
        w.src = req.legacyMode ? addrIn.ch0Cur : addrIn.srcAddr;
        w.dst = req.legacyMode ? addrIn.ch1Cur : addrIn.dstAddr;
        w.data = word;
        notes.push_back(w);
        busGrant = 1;
        @(posedge clk);
        #1;
        k = 0;
        while (stateCode !== 6'h01 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        check(k == (w.io ? 0 : 5 + waitCycles), "sequence length");
    endtask : run_one
    always @(posedge clk) begin
        if (nrst && stateCode === 6'h02 && notes.size() > 0)
            check(bus.addr === notes[0].src, "source address");
        if (nrst && (writeStart === 1'b1 || ioPath === 1'b1)) begin
            check(notes.size() > 0, "unexpected transfer");
            n = notes.pop_front();
            check(ioPath === n.io, "transfer kind");
            check(n.io || bus.addr === n.dst, "destination");
            check(n.io || tempData === n.data, "captured word");
            check(n.io || eopPending === n.eop, "eop flag");
        end
    end
    initial begin
        #5000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1;
        nrst = 1;
        check(stateCode === 6'h01 && bus.memRdN === 1'b1, "reset state");
        for (i = 0; i < 24; i++)
            run_one();
        // reset in mid transfer: back to idle, bus released
        req.legacyMode = 1'b0;
        req.modeReg[MODE_M2M_BIT] = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        nrst = 0;
        busGrant = 0;
        @(posedge clk);
        #1;
        nrst = 1;
        check(stateCode === 6'h01 && bus.aen === 1'b0
            && bus.memRdN === 1'b1 && eopPending === 1'b0, "mid reset");
        $display("mid-run reset done");
        repeat (4) @(posedge clk);
        $display("random transfers done");
        complete_run();
    end
endmodule : dmmrp_read_phase_tb
